/* logic/ars_pkg.sv */
// Package: constants and carrier types for the auto restart supervisor
package ars_pkg;
	// ------------------------------------------------------------
	// Mode codes
	// ------------------------------------------------------------
	localparam logic [4:0] MODE_PF_AUTO = 5'h04;
	localparam logic [4:0] MODE_FAULT_AUTO = 5'h06;
	localparam logic [4:0] MODE_PF_MANUAL = 5'h0e;
	localparam logic [4:0] MODE_FAULT_MANUAL = 5'h10;
	localparam logic [4:0] MODE_ALL_ACK = 5'h1a;
	// ------------------------------------------------------------
	// Widths, defaults and timing
	// ------------------------------------------------------------
	localparam int TIME_W = 16;
	localparam int FAULT_W = 16;
	localparam int ATTEMPT_W = 8;
	localparam int LIST_LEN = 10;
	localparam logic [TIME_W-1:0] SUPERVISION_DEFAULT_S = 16'h003c;
	localparam logic [TIME_W-1:0] WINDOW_DEFAULT_S = 16'h0000;
	localparam logic [FAULT_W-1:0] COMM_LOSS_FAULT_NUM = 16'h2135;
	localparam int CLK_HZ = 125000000;
	localparam int SUCCESS_HOLD_MS = 1000;
	localparam logic [ATTEMPT_W-1:0] ONE_ATTEMPT = 8'h01;
	localparam logic [TIME_W-1:0] TIME_ZERO = 16'h0000;
	localparam logic [TIME_W-1:0] TIME_ONE = 16'h0001;

	// Configuration carried as one group
	typedef struct packed {
		logic [4:0] restart_mode_select;
		logic [TIME_W-1:0] restart_supervision_time;
		logic [TIME_W-1:0] counter_reset_window;
		logic [ATTEMPT_W-1:0] start_attempt_limit;
	} cfg_type;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RESTART = 2'b01,
		ST_PROVE = 2'b10,
		ST_ABORTED = 2'b11
	} state_type;
endpackage

/* logic/auto_restart_supervisor.sv */
// Auto restart supervisor: supervision timers, attempt counting and suppression list
// Notes on behaviour
// - Supervision window is configurable; default is sixty seconds.
// - Both timers act only in mode codes 4, 6, 14, 16, 26.
// - Supervision timer starts at fault detection, stops on successful start.
// - Supervision expiry before successful start raises restart-failed fault.
// - Supervision time zero disables the supervision timer completely.
// - Counter-reset window defaults zero, starts each success, ends at expiry.
// - More successes than limit inside window aborts restart, raises fault.
// - Ten-entry fault list; matching faults do not trigger restart.
// - List suppression only in modes 6, 16 or 26.
// - Fieldbus loss faults; modes 6, 16, 26 auto-acknowledge and restart.
// - Attempt counter decrements per acknowledgement, reloads after window expiry.
// - Attempt succeeds if no fault within one second after magnetization.
module auto_restart_supervisor
	import ars_pkg::*;
#(
	parameter int SUCCESS_HOLD_CYCLES = CLK_HZ / 1000 * SUCCESS_HOLD_MS
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic tick_1s_i,
	input wire cfg_type cfg_i,
	input wire logic [LIST_LEN*FAULT_W-1:0] restart_suppress_list_i,
	input wire logic fault_valid_i,
	input wire logic [FAULT_W-1:0] fault_num_i,
	input wire logic comm_loss_fault_i,
	input wire logic ack_i,
	input wire logic run_command_i,
	input wire logic magnetization_done_flag_i,
	output logic restart_request_o,
	output logic auto_ack_o,
	output logic restart_failed_fault_o,
	output logic [ATTEMPT_W-1:0] attempts_left_o,
	output logic supervision_active_o,
	output logic window_active_o
);
	// Elaboration check: a proving window needs at least one cycle
	if (SUCCESS_HOLD_CYCLES < 1) begin : g_bad_hold
		$error("hold count must be positive");
	end

	// ------------------------------------------------------------
	// Decode of mode and fault events
	// ------------------------------------------------------------
	state_type state_reg;
	logic [31:0] hold_reg;
	logic [TIME_W-1:0] sup_cnt_reg, win_cnt_reg;
	logic [ATTEMPT_W-1:0] attempts_reg, successes_reg;
	logic sup_on_reg, win_on_reg, fail_reg, ack_pulse_reg;
	logic timed_mode, list_mode, fault_evt, suppressed, success, sup_expire, win_expire;
	logic over_limit;

	assign timed_mode = (cfg_i.restart_mode_select == MODE_PF_AUTO) ||
		(cfg_i.restart_mode_select == MODE_FAULT_AUTO) || (cfg_i.restart_mode_select == MODE_PF_MANUAL) ||
		(cfg_i.restart_mode_select == MODE_FAULT_MANUAL) || (cfg_i.restart_mode_select == MODE_ALL_ACK);
	assign list_mode = (cfg_i.restart_mode_select == MODE_FAULT_AUTO) ||
		(cfg_i.restart_mode_select == MODE_FAULT_MANUAL) || (cfg_i.restart_mode_select == MODE_ALL_ACK);

	// Suppression list search over all entries
	always_comb begin
		suppressed = 1'b0;
		for (int i = 0; i < LIST_LEN; i++) begin
			if (restart_suppress_list_i[i*FAULT_W +: FAULT_W] == (comm_loss_fault_i ? COMM_LOSS_FAULT_NUM : fault_num_i))
				suppressed = list_mode;
		end
	end

	// Comm loss raises a fault event of its own
	assign fault_evt = fault_valid_i || comm_loss_fault_i;
	assign success = (state_reg == ST_PROVE) && !fault_evt && (hold_reg >= SUCCESS_HOLD_CYCLES - 1);
	assign sup_expire = sup_on_reg && tick_1s_i && (sup_cnt_reg + TIME_ONE >= cfg_i.restart_supervision_time);
	assign win_expire = win_on_reg && tick_1s_i && (win_cnt_reg + TIME_ONE >= cfg_i.counter_reset_window);
	assign over_limit = success && (successes_reg >= cfg_i.start_attempt_limit) && win_on_reg;

	// ------------------------------------------------------------
	// Restart sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			hold_reg <= '0;
		end else if (ce_i) begin
			case (state_reg)
				ST_IDLE: begin
					if (fault_evt && timed_mode && !suppressed)
						state_reg <= ST_RESTART;
				end
				ST_RESTART: begin
					hold_reg <= '0;
					if (sup_expire || attempts_reg == '0)
						state_reg <= ST_ABORTED;
					else if (run_command_i && magnetization_done_flag_i)
						state_reg <= ST_PROVE;
				end
				ST_PROVE: begin
					hold_reg <= hold_reg + 32'h1;
					if (fault_evt)
						state_reg <= suppressed ? ST_IDLE : ST_RESTART;
					else if (over_limit || sup_expire)
						state_reg <= ST_ABORTED;
					else if (success)
						state_reg <= ST_IDLE;
				end
				ST_ABORTED: begin
					if (ack_i && !run_command_i)
						state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Restart-failed fault, set wins over acknowledge
	always_ff @(posedge clk_sys_i) begin
		if (rst_i)
			fail_reg <= 1'b0;
		else if (ce_i) begin
			if (state_reg != ST_ABORTED && (sup_expire || over_limit ||
				(state_reg == ST_RESTART && attempts_reg == '0)))
				fail_reg <= 1'b1;
			else if (state_reg == ST_ABORTED && ack_i && !run_command_i)
				fail_reg <= 1'b0;
		end
	end

	// Supervision timer on the timebase tick
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sup_on_reg <= 1'b0;
			sup_cnt_reg <= TIME_ZERO;
		end else if (ce_i) begin
			if (success || sup_expire || !timed_mode || cfg_i.restart_supervision_time == TIME_ZERO ||
				state_reg == ST_ABORTED || (state_reg == ST_RESTART && attempts_reg == '0)) begin
				sup_on_reg <= 1'b0;
				sup_cnt_reg <= TIME_ZERO;
			end else if (state_reg == ST_IDLE && fault_evt && !suppressed) begin
				sup_on_reg <= 1'b1;
				sup_cnt_reg <= TIME_ZERO;
			end else if (sup_on_reg && tick_1s_i)
				sup_cnt_reg <= sup_cnt_reg + TIME_ONE;
		end
	end

	// Counter-reset window and success count
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			win_on_reg <= 1'b0;
			win_cnt_reg <= TIME_ZERO;
			successes_reg <= '0;
		end else if (ce_i) begin
			if (!timed_mode || win_expire) begin
				win_on_reg <= 1'b0;
				win_cnt_reg <= TIME_ZERO;
				successes_reg <= '0;
			end else if (success) begin
				win_on_reg <= (cfg_i.counter_reset_window != TIME_ZERO);
				win_cnt_reg <= TIME_ZERO;
				successes_reg <= win_on_reg ? successes_reg + ONE_ATTEMPT : ONE_ATTEMPT;
			end else if (win_on_reg && tick_1s_i)
				win_cnt_reg <= win_cnt_reg + TIME_ONE;
		end
	end

	// Attempt counter with acknowledge pulse
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			attempts_reg <= '0;
			ack_pulse_reg <= 1'b0;
		end else if (ce_i) begin
			ack_pulse_reg <= (state_reg == ST_IDLE) && fault_evt && timed_mode && !suppressed;
			if (win_expire || state_reg == ST_ABORTED || !timed_mode)
				attempts_reg <= cfg_i.start_attempt_limit;
			else if (ack_pulse_reg && attempts_reg != '0)
				attempts_reg <= attempts_reg - ONE_ATTEMPT;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign restart_request_o = (state_reg == ST_RESTART) && run_command_i;
	assign auto_ack_o = ack_pulse_reg;
	assign restart_failed_fault_o = fail_reg;
	assign attempts_left_o = attempts_reg;
	assign supervision_active_o = sup_on_reg;
	assign window_active_o = win_on_reg;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	chk_sup_zero_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && cfg_i.restart_supervision_time == TIME_ZERO |=> !sup_on_reg) else $error("supervision runs at zero");
	chk_mode_gate: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && !timed_mode |=> !sup_on_reg && !win_on_reg) else $error("timer active in bad mode");
	chk_expire_fault: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && sup_expire |=> fail_reg) else $error("expiry without fault");
	chk_limit_abort: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && over_limit && !fault_evt |=> state_reg == ST_ABORTED && fail_reg) else $error("limit not aborted");
	chk_success_stop: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && success |=> !sup_on_reg) else $error("supervision not stopped");
	chk_fault_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		fail_reg && !ack_i |=> fail_reg) else $error("fault cleared without ack");
	chk_suppress_list: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && state_reg == ST_IDLE && suppressed |=> state_reg == ST_IDLE) else $error("suppressed fault restarted");
	chk_window_reload: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && win_expire |=> attempts_reg == $past(cfg_i.start_attempt_limit)) else $error("no reload");
	cov_restart: cover property (@(posedge clk_sys_i) state_reg == ST_RESTART ##1 state_reg == ST_PROVE);
	cov_abort: cover property (@(posedge clk_sys_i) state_reg == ST_ABORTED);
	chk_abort_attempts: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && state_reg == ST_RESTART && attempts_reg == '0 |=> state_reg == ST_ABORTED && fail_reg)
		else $error("attempts spent without abort");
	chk_auto_ack: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && state_reg == ST_IDLE && fault_evt && timed_mode && !suppressed |=> auto_ack_o)
		else $error("fault not acknowledged");
	chk_window_start: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		ce_i && success && timed_mode && !win_expire && cfg_i.counter_reset_window != TIME_ZERO |=> win_on_reg)
		else $error("window not started");
	// Cover points for the main scenarios
	cov_success: cover property (@(posedge clk_sys_i) success);
	cov_window_expire: cover property (@(posedge clk_sys_i) win_expire);
	cov_over_limit: cover property (@(posedge clk_sys_i) over_limit);
endmodule // auto_restart_supervisor

/* verif/ctrl_model.sv */
// Controller model: run command, acknowledge and magnetization flag
module ctrl_model #(
	parameter int MAG_DELAY = 4
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic run_en_i,
	input wire logic ack_en_i,
	input wire logic restart_request_i,
	input wire logic restart_failed_fault_i,
	output logic run_command_o,
	output logic ack_o,
	output logic magnetization_done_flag_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int mag_cnt;
	// Acknowledge with run off; run again only once the fault is gone
	always_ff @(posedge clk_sys_i) begin
		ack_o <= !rst_i && ack_en_i && restart_failed_fault_i;
		run_command_o <= !rst_i && run_en_i && !restart_failed_fault_i;
		mag_cnt <= (rst_i || !run_command_o) ? 0 : mag_cnt + int'(restart_request_i);
		magnetization_done_flag_o <= !rst_i && run_command_o && mag_cnt >= MAG_DELAY;
	end
endmodule // ctrl_model

/* verif/auto_restart_supervisor_tb_top.sv */
// Testbench top: directed sequences for the auto restart supervisor
module auto_restart_supervisor_tb_top
	import ars_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 0, rst_i = 1, ce_i = 1, tick_1s_i = 0, fault_valid_i = 0, comm_loss_fault_i = 0;
	logic run_en = 0, ack_en = 0, run_command, ack, mag_done, restart_request, auto_ack, fail, sup_on, win_on;
	logic [FAULT_W-1:0] fault_num_i = 16'h0000;
	logic [LIST_LEN*FAULT_W-1:0] list = '0;
	logic [ATTEMPT_W-1:0] attempts_left;
	cfg_type cfg = '{5'h00, SUPERVISION_DEFAULT_S, WINDOW_DEFAULT_S, 8'h03};
	int miscompares = 0, checks_done = 0, tick_div = 0, ack_cnt = 0;
	// -----------------------------------------------------------
	// Clock, one-second timebase (ten cycles) and pulse counter
	// -----------------------------------------------------------
	always #4 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		tick_div <= (tick_div == 9) ? 0 : tick_div + 1;
		tick_1s_i <= (tick_div == 9);
		ack_cnt <= ack_cnt + int'(auto_ack === 1'b1);
	end
	auto_restart_supervisor #(.SUCCESS_HOLD_CYCLES(20)) dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.ce_i(ce_i), .tick_1s_i(tick_1s_i), .cfg_i(cfg), .restart_suppress_list_i(list),
		.fault_valid_i(fault_valid_i), .fault_num_i(fault_num_i), .comm_loss_fault_i(comm_loss_fault_i),
		.ack_i(ack), .run_command_i(run_command), .magnetization_done_flag_i(mag_done),
		.restart_request_o(restart_request), .auto_ack_o(auto_ack), .restart_failed_fault_o(fail),
		.attempts_left_o(attempts_left), .supervision_active_o(sup_on), .window_active_o(win_on));
	ctrl_model #(.MAG_DELAY(4)) ctrl_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .run_en_i(run_en),
		.ack_en_i(ack_en), .restart_request_i(restart_request), .restart_failed_fault_i(fail),
		.run_command_o(run_command), .ack_o(ack), .magnetization_done_flag_o(mag_done));
	// -----------------------------------------------------------
	// Tasks
	// -----------------------------------------------------------
	task step(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One-cycle fault, by number or as fieldbus loss
	task raise(input logic [FAULT_W-1:0] num, input logic bus);
		@(posedge clk_sys_i);
		fault_valid_i <= !bus;
		comm_loss_fault_i <= bus;
		fault_num_i <= num;
		@(posedge clk_sys_i);
		fault_valid_i <= 1'b0;
		comm_loss_fault_i <= 1'b0;
	endtask
	// Let the controller run until the attempt is proven
	task succeed;
		run_en <= 1'b1;
		step(40);
		check(sup_on, 1'b0);
		run_en <= 1'b0;
		step(3);
	endtask
	task finish_test;
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		#100us;
		miscompares++;
		finish_test();
	end
	// -----------------------------------------------------------
	// Directed sequences
	// -----------------------------------------------------------
	initial begin
		step(5);
		rst_i <= 1'b0;
		step(3);
		check({fail, sup_on, win_on}, 3'b000);
		raise(16'h1234, 1'b0);
		step(5);
		check({ack_cnt[7:0], sup_on}, 9'h000);
		cfg.restart_mode_select <= MODE_FAULT_AUTO;
		list[15:0] <= 16'h1234;
		list[31:16] <= COMM_LOSS_FAULT_NUM;
		raise(16'h1234, 1'b0);
		raise(16'h0000, 1'b1);
		step(5);
		check({ack_cnt[7:0], sup_on}, 9'h000);
		cfg.restart_mode_select <= MODE_PF_AUTO;
		raise(16'h1234, 1'b0);
		step(3);
		check({ack_cnt[7:0], sup_on}, 9'h003);
		check(attempts_left, 8'h02);
		succeed();
		cfg.restart_mode_select <= MODE_FAULT_AUTO;
		cfg.restart_supervision_time <= 16'h0003;
		list <= '0;
		raise(16'h0000, 1'b1);
		step(3);
		check(ack_cnt[7:0], 8'h02);
		step(45);
		check(fail, 1'b1);
		ack_en <= 1'b1;
		step(5);
		ack_en <= 1'b0;
		check(fail, 1'b0);
		cfg.restart_supervision_time <= TIME_ZERO;
		raise(16'h0042, 1'b0);
		step(100);
		check(fail, 1'b0);
		succeed();
		cfg.restart_mode_select <= 5'h00;
		cfg.restart_supervision_time <= SUPERVISION_DEFAULT_S;
		cfg.counter_reset_window <= 16'h0003;
		step(2);
		check(attempts_left, 8'h03);
		cfg.restart_mode_select <= MODE_FAULT_AUTO;
		raise(16'h0042, 1'b0);
		succeed();
		check({win_on, attempts_left}, 9'h102);
		step(30);
		check({win_on, attempts_left}, 9'h003);
		cfg.counter_reset_window <= 16'h0032;
		cfg.start_attempt_limit <= 8'h01;
		raise(16'h0042, 1'b0);
		succeed();
		check(win_on, 1'b1);
		raise(16'h0042, 1'b0);
		succeed();
		check(fail, 1'b1);
		check(attempts_left, 8'h01);
		finish_test();
	end
endmodule // auto_restart_supervisor_tb_top
